//--- design/ifeb_pkg.sv
// Package for the interrupt flag and enable bank
package ifeb_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_FLAG = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_PART_CFG = 8'h14;

  // Flag bank two bit positions
  localparam int FLG_SERIAL2_ERR = 0;
  localparam int FLG_SERIAL2_EVT = 1;
  localparam int FLG_CAN_RX = 2;
  localparam int FLG_CAN_EVT = 3;
  localparam int FLG_XFER3 = 4;
  localparam int FLG_PARALLEL = 13;
  localparam int FLG_XFER4 = 14;
  localparam logic [15:0] FLAG_IMPL_MASK = 16'h601f;
  localparam logic [15:0] CAN_FLAG_MASK = 16'h000c;

  // Enable bank one bit positions
  localparam int EN_CAPTURE8 = 7;
  localparam int EN_COMPARE3 = 9;
  localparam logic [15:0] ENABLE_IMPL_MASK = 16'hffdf;

  // Values after reset
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // Sticky bus-side events
  localparam int EV_FLAG_REQ = 0;
  localparam int EV_ENABLE_REQ = 1;

  typedef struct packed {
    logic [15:0] flag_req;
    logic [15:0] enable_req;
  } ifeb_req_t;

endpackage : ifeb_pkg

//--- design/ifeb_sync.sv
// Two-stage synchroniser bank for source event lines
`timescale 1ns/1ps
`default_nettype none
module ifeb_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Lines
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_a;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_a <= '0;
      sync_out <= '0;
    end else begin
      stage_a <= async_in;
      sync_out <= stage_a;
    end
  end

endmodule : ifeb_sync
`default_nettype wire

//--- design/ifeb_top.sv
// Interrupt flag and enable bank with APB slave
// Behaviour
// [R1] Flag bits read 1 after their request occurred, read/write by software, reset 0.
// [R2] Enable bit 1 enables its source request; 0 disables; reset 0.
// [R3] Without CAN controller, CAN event and receive requests stay disabled.
// [R4] Capture channel 8 enable sits at enable bit 7.
// [R5] Compare channel 3 enable sits at enable bit 9.
// [R6] Event sets flag until software writes 0; request needs flag and enable (flag_req here takes the flag alone, no enable); unimplemented read 0.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ifeb_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Source events, asynchronous
  input wire logic [15:0] flag_event,
  input wire logic [15:0] enable_src_event,
  // Requests to the core
  output ifeb_pkg::ifeb_req_t core_req,
  // Bus interrupt
  output logic irq
);

  logic [15:0] flag_event_s;
  logic [15:0] en_src_s;
  logic [15:0] flag_status_bank_two;
  logic [15:0] enable_control_bank_one;
  logic [15:0] enable_src_pending;
  logic can_present;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic bus_wr;
  logic setup_rd;
  logic addr_ok;
  logic flag_wr;
  logic enable_wr;
  logic irq_enable_wr;
  logic irq_clear_wr;
  logic cfg_wr;
  logic [15:0] next_flag;
  logic [15:0] flag_gate;
  logic [15:0] next_flag_req;
  logic [15:0] next_enable_req;
  logic [1:0] new_ev;
  logic [31:0] rd_word;

  // Flag bank sources
  ifeb_sync #(.WIDTH(16)) u_sync_flag (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(flag_event),
    .sync_out(flag_event_s)
  );

  // Enable bank sources
  ifeb_sync #(.WIDTH(16)) u_sync_en (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(enable_src_event),
    .sync_out(en_src_s)
  );

  // Zero wait states: the access phase is always the last cycle
  assign bus_wr = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  // Writes land at the access edge; unmapped addresses hit no strobe
  assign flag_wr = bus_wr && paddr == ifeb_pkg::ADDR_FLAG;
  assign enable_wr = bus_wr && paddr == ifeb_pkg::ADDR_ENABLE;
  assign irq_enable_wr = bus_wr && paddr == ifeb_pkg::ADDR_IRQ_ENABLE;
  assign irq_clear_wr = bus_wr && paddr == ifeb_pkg::ADDR_IRQ_CLEAR;
  assign cfg_wr = bus_wr && paddr == ifeb_pkg::ADDR_PART_CFG;

  always_comb begin
    unique case (paddr)
      ifeb_pkg::ADDR_FLAG, ifeb_pkg::ADDR_ENABLE, ifeb_pkg::ADDR_IRQ_STATUS,
      ifeb_pkg::ADDR_IRQ_ENABLE, ifeb_pkg::ADDR_IRQ_CLEAR, ifeb_pkg::ADDR_PART_CFG: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // One flag cell per bit; a source event beats a same-cycle write of 0
  for (genvar gi = 0; gi < 16; gi++) begin : g_flag
    if (ifeb_pkg::FLAG_IMPL_MASK[gi]) begin : g_impl
      assign next_flag[gi] = flag_event_s[gi] || (flag_wr ? pwdata[gi] : flag_status_bank_two[gi]); // R1 R6
    end else begin : g_unimpl
      assign next_flag[gi] = 1'b0; // R6
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_status_bank_two <= ifeb_pkg::FLAG_RESET; // R1
    end else begin
      flag_status_bank_two <= next_flag; // R1 R6
    end
  end

  // Enable bank, bit 5 unimplemented
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_control_bank_one <= ifeb_pkg::ENABLE_RESET; // R2
    end else if (enable_wr) begin
      enable_control_bank_one <= pwdata[15:0] & ifeb_pkg::ENABLE_IMPL_MASK; // R2 R4 R5 R6
    end
  end

  // Enable-bank sources latch here; their flags live elsewhere, so no clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_src_pending <= '0;
    end else begin
      enable_src_pending <= (enable_src_pending | en_src_s) & ifeb_pkg::ENABLE_IMPL_MASK;
    end
  end

  // Part option: CAN controller present; reset leaves it absent
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      can_present <= 1'b0;
    end else if (cfg_wr) begin
      can_present <= pwdata[0];
    end
  end

  // CAN requests stay off while the controller is absent
  always_comb begin
    flag_gate = 16'hffff;
    if (!can_present) begin
      flag_gate = ~ifeb_pkg::CAN_FLAG_MASK; // R3
    end
    next_flag_req = flag_status_bank_two & flag_gate; // R6
    next_enable_req = enable_src_pending & enable_control_bank_one; // R2 R4 R5
  end

  // Status events fire when a request word leaves the all-quiet state
  always_comb begin
    new_ev = '0;
    new_ev[ifeb_pkg::EV_FLAG_REQ] = |next_flag_req && !(|core_req.flag_req);
    new_ev[ifeb_pkg::EV_ENABLE_REQ] = |next_enable_req && !(|core_req.enable_req);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_req <= '0;
    end else begin
      core_req.flag_req <= next_flag_req;
      core_req.enable_req <= next_enable_req;
    end
  end

  // Sticky status: set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status <= ifeb_pkg::IRQ_RESET;
    end else if (irq_clear_wr) begin
      irq_status <= (irq_status & ~pwdata[1:0]) | new_ev;
    end else begin
      irq_status <= irq_status | new_ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_enable <= ifeb_pkg::IRQ_RESET;
    end else if (irq_enable_wr) begin
      irq_enable <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // Read word, decoded from the setup-phase address
  always_comb begin
    unique case (paddr)
      ifeb_pkg::ADDR_FLAG: rd_word = {16'h0000, flag_status_bank_two}; // R1 R6
      ifeb_pkg::ADDR_ENABLE: rd_word = {16'h0000, enable_control_bank_one}; // R2
      ifeb_pkg::ADDR_IRQ_STATUS: rd_word = {30'h0, irq_status};
      ifeb_pkg::ADDR_IRQ_ENABLE: rd_word = {30'h0, irq_enable};
      ifeb_pkg::ADDR_PART_CFG: rd_word = {31'h0, can_present};
      default: rd_word = '0;
    endcase
  end

  // Ready one cycle after setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Error alongside ready on an unmapped address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Read data stands only with ready
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else begin
      prdata <= setup_rd ? rd_word : '0;
    end
  end

endmodule : ifeb_top
`default_nettype wire

//--- tb/ifeb_src_model.sv
// Peripheral event source model
`timescale 1ns/1ps
`default_nettype none
module ifeb_src_model (
  // Clock and command
  input wire logic clk,
  input wire logic fire,
  input wire logic [31:0] pat,
  // Event lines
  output logic [15:0] flag_event = 16'h0,
  output logic [15:0] enable_src_event = 16'h0
);
  logic [1:0] hold = 2'h0;
  // Pulse held three cycles so the synchroniser sees it
  always @(posedge clk) begin
    hold <= fire ? 2'h2 : hold - {1'b0, |hold};
    {enable_src_event, flag_event} <= (fire || hold != 2'h0) ? pat : 32'h0;
  end
endmodule : ifeb_src_model
`default_nettype wire

//--- tb/ifeb_top_asserts.sv
// Port assertions for the interrupt bank
`timescale 1ns/1ps
`default_nettype none
module ifeb_top_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] flag_event,
  input wire ifeb_pkg::ifeb_req_t core_req,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Mirror of the CAN-present option, taken at the access edge
  logic cfg_can;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_can <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == ifeb_pkg::ADDR_PART_CFG) begin
      cfg_can <= pwdata[0];
    end
  end
  a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h14 |=> pslverr) else $error("no err");
  a_can_gated: assert property (!cfg_can && !$past(cfg_can) |-> core_req.flag_req[3:2] == 2'h0) else $error("can req");
  a_flag_impl: assert property ((core_req.flag_req & ~ifeb_pkg::FLAG_IMPL_MASK) == 16'h0) else $error("flag");
  a_en_impl: assert property (core_req.enable_req[5] == 1'b0) else $error("en bit");
  a_evt_req: assert property ($rose(flag_event[14]) |-> ##[3:5] core_req.flag_req[14]) else $error("late");
  a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n |=> !irq && core_req == '0) else $error("reset");
  cover property (irq);
  cover property (pslverr);
  cover property (core_req.enable_req[9]);
  cover property (cfg_can && core_req.flag_req[3]);
endmodule : ifeb_top_asserts
bind ifeb_top ifeb_top_asserts u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flag_event(flag_event),
  .core_req(core_req), .irq(irq));
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the interrupt bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fire = 1'b0;
  logic [31:0] pat = 32'h0;
  logic [15:0] fev;
  logic [15:0] eev;
  ifeb_pkg::ifeb_req_t req;
  logic irq;
  logic [32:0] q[$];
  logic [32:0] note;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [15:0] v;
  always #2.5 clk = ~clk;
  ifeb_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flag_event(fev),
    .enable_src_event(eev), .core_req(req), .irq(irq));
  ifeb_src_model src (.clk(clk), .fire(fire), .pat(pat), .flag_event(fev), .enable_src_event(eev));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back({1'b0, e});
    wr(1'b0, a, 32'h0);
  endtask : rd
  task automatic rd_err(input logic [7:0] a);
    q.push_back({1'b1, 32'h0});
    wr(1'b0, a, 32'h0);
  endtask : rd_err
  task automatic ev(input logic [31:0] p);
    pat <= p;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : ev
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      note = q.pop_front();
      chk(prdata, note[31:0]);
      chk({31'h0, pslverr}, {31'h0, note[32]});
    end
  end
  initial begin
    v = 16'($urandom(78));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ifeb_pkg::ADDR_FLAG, 32'h0);
    rd(ifeb_pkg::ADDR_ENABLE, 32'h0);
    rd_err(8'h1c);
    v = 16'($urandom);
    wr(1'b1, ifeb_pkg::ADDR_ENABLE, {16'h0, v});
    rd(ifeb_pkg::ADDR_ENABLE, {16'h0, v & ifeb_pkg::ENABLE_IMPL_MASK});
    ev(32'h0000ffff);
    rd(ifeb_pkg::ADDR_FLAG, {16'h0, ifeb_pkg::FLAG_IMPL_MASK});
    chk({16'h0, req.flag_req}, 32'h6013);
    chk({31'h0, irq}, 32'h0);
    rd(ifeb_pkg::ADDR_IRQ_STATUS, 32'h1);
    wr(1'b1, ifeb_pkg::ADDR_IRQ_ENABLE, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(1'b1, ifeb_pkg::ADDR_IRQ_CLEAR, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(1'b1, ifeb_pkg::ADDR_FLAG, 32'h0);
    chk({16'h0, req.flag_req}, 32'h0);
    wr(1'b1, ifeb_pkg::ADDR_ENABLE, 32'h0280);
    ev(32'hffff0000);
    chk({16'h0, req.enable_req}, 32'h0280);
    rd(ifeb_pkg::ADDR_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(1'b1, ifeb_pkg::ADDR_ENABLE, 32'h0);
    chk({16'h0, req.enable_req}, 32'h0);
    wr(1'b1, ifeb_pkg::ADDR_PART_CFG, 32'h1);
    rd(ifeb_pkg::ADDR_PART_CFG, 32'h1);
    ev({16'h0, ifeb_pkg::CAN_FLAG_MASK});
    chk({16'h0, req.flag_req}, {16'h0, ifeb_pkg::CAN_FLAG_MASK});
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ifeb_pkg::ADDR_FLAG, 32'h0);
    rd(ifeb_pkg::ADDR_PART_CFG, 32'h0);
    rd(ifeb_pkg::ADDR_IRQ_ENABLE, 32'h0);
    chk({16'h0, req.flag_req}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    report_and_stop;
  end
  initial begin
    #5000;
    n_mismatch++;
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
